/* File: design/pesel_pkg.sv */
// Package of constants and types for the port E low pin function select block.
package pesel_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [11:0] PESEL_CTRL2_OFFSET = 12'h000;
    localparam logic [11:0] PESEL_STATUS_OFFSET = 12'h004;
    localparam logic [15:0] PESEL_CTRL2_WMASK = 16'h3fff;
    localparam logic [15:0] PESEL_CTRL2_RESET = 16'h0000;
    // Fields of pins 6, 5, 4 and 0 come up as ones in the 8-bit external boot mode.
    localparam logic [15:0] PESEL_CTRL2_RESET_EXT8 = 16'h3f03;
    localparam int PESEL_NUM_PINS = 7;
    // ------------------------------------------------------------
    // Mode codes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PESEL_MODE_PORT = 2'h0,
        PESEL_MODE_TIMER = 2'h1,
        PESEL_MODE_SERIAL = 2'h2,
        PESEL_MODE_BUS = 2'h3
    } pesel_mode_e;
    // AXI responses.
    localparam logic [1:0] PESEL_RESP_OKAY = 2'h0;
    localparam logic [1:0] PESEL_RESP_SLVERR = 2'h2;
    // Bit of the status register that flags a prohibited code.
    localparam int PESEL_STATUS_BAD_POS = 7;
endpackage

/* File: design/pesel_edge_if.sv */
// Interface carrying pin levels and edge-mode selects to the edge watcher.
`timescale 1ns/1ps
interface pesel_edge_if #(parameter int N = 2);
    logic [N-1:0] pin_level;
    logic [N-1:0] edge_mode;
    logic [N-1:0] edge_event;
    modport watcher (input pin_level, input edge_mode, output edge_event);
    modport user (output pin_level, output edge_mode, input edge_event);
endinterface

/* File: design/pesel_edge_watch.sv */
// Falling-edge watcher for pins shared with DMA request or interrupt inputs.
`timescale 1ns/1ps
module pesel_edge_watch
    import pesel_pkg::*;
#(
    parameter int N = 2
) (
    input wire logic clk_sys,
    input wire logic rstn,
    pesel_edge_if.watcher eif
);
    typedef struct packed {
        logic [N-1:0] level;
        logic [N-1:0] mode;
        logic [N-1:0] event_out;
    } pesel_ew_s;
    pesel_ew_s st_ff;
    pesel_ew_s nxt_st;

    if (N < 1) begin : g_bad_width
        $error("N must be at least 1");
    end

    // A pin that is low while the edge mode is switched on counts as an edge, as if it had just fallen.
    always_comb begin
        nxt_st = st_ff;
        nxt_st.level = eif.pin_level;
        nxt_st.mode = eif.edge_mode;
        for (int i = 0; i < N; i++) begin
            nxt_st.event_out[i] = eif.edge_mode[i] & ~eif.pin_level[i] & (st_ff.level[i] | ~st_ff.mode[i]);
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign eif.edge_event = st_ff.event_out;

    a_switch_low_edge: assert property (@(posedge clk_sys) disable iff (!rstn)
        (!eif.pin_level[0] && $rose(eif.edge_mode[0])) |=> eif.edge_event[0])
        else $error("switch to edge mode at low level gave no edge");
endmodule // pesel_edge_watch

/* File: design/pesel_top.sv */
// Port E low pin function select with AXI4-Lite register access.
//
// Our own choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// Summary of operation
// - Pin 6: port, timer ch2 A, serial3 clock, or address bit 8.
// - Pin 5: port, timer ch1 B, serial3 transmit, or address bit 7.
// - Pin 4: port, timer ch1 A, serial3 receive, or address bit 6.
// - Pin 3: port or timer ch0 D; codes 10 and 11 forbidden.
// - Pin 2: port or timer ch0 C; codes 10 and 11 forbidden.
// - Pin 1: port or timer ch0 B; codes 10 and 11 forbidden.
// - Pin 0: port, timer ch0 A, or chip select zero; code 10 forbidden.
// - Pin 6,5,4,0 fields reset to ones in 8-bit external boot, else zero.
// - Switching a low pin into edge detection registers an edge.
module pesel_top
    import pesel_pkg::*;
#(
    parameter int EDGE_PINS = 2
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic boot_ext8,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [6:0] port_out,
    input wire logic [6:0] port_oe,
    input wire logic timer_ch2_a_io_o,
    input wire logic timer_ch2_a_io_oe,
    input wire logic timer_ch1_b_io_o,
    input wire logic timer_ch1_b_io_oe,
    input wire logic timer_ch1_a_io_o,
    input wire logic timer_ch1_a_io_oe,
    input wire logic timer_ch0_d_io_o,
    input wire logic timer_ch0_d_io_oe,
    input wire logic timer_ch0_c_io_o,
    input wire logic timer_ch0_c_io_oe,
    input wire logic timer_ch0_b_io_o,
    input wire logic timer_ch0_b_io_oe,
    input wire logic timer_ch0_a_io_o,
    input wire logic timer_ch0_a_io_oe,
    input wire logic serial3_clock_o,
    input wire logic serial3_clock_oe,
    input wire logic serial3_transmit,
    input wire logic [2:0] ext_addr_hi,
    input wire logic chip_select_zero_n,
    input wire logic [6:0] pin_in,
    output logic [6:0] pin_out,
    output logic [6:0] pin_oe,
    output logic [6:0] pin_to_port,
    output logic [6:0] pin_timer_sel,
    output logic serial3_clock_in,
    output logic serial3_receive,
    input wire logic [EDGE_PINS-1:0] edge_pin_level,
    input wire logic [EDGE_PINS-1:0] edge_mode,
    output logic [EDGE_PINS-1:0] edge_event
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [15:0] ctrl;
        logic boot_pend;
        logic aw_got;
        logic w_got;
        logic [11:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [6:0] pout;
        logic [6:0] poe;
    } pesel_st_s;
    pesel_st_s st_ff;
    pesel_st_s nxt_st;
    logic [1:0] mode [PESEL_NUM_PINS];
    logic [6:0] bad;

    if (EDGE_PINS < 1 || EDGE_PINS > 8) begin : g_bad_edge_pins
        $error("EDGE_PINS must be 1 to 8");
    end

    // Prohibited codes fall back to the port, so a stray write never lets a peripheral drive the pin.
    function automatic logic [1:0] pesel_legal(input logic [1:0] code, input logic [1:0] allowed_mask);
        if (code == 2'h0 || (code == 2'h3 && allowed_mask[1]) || (code == 2'h2 && allowed_mask[0]) ||
            code == 2'h1) begin
            return code;
        end
        return 2'h0;
    endfunction

    // ------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------
    always_comb begin
        mode[6] = pesel_legal(st_ff.ctrl[13:12], 2'h3);
        mode[5] = pesel_legal(st_ff.ctrl[11:10], 2'h3);
        mode[4] = pesel_legal(st_ff.ctrl[9:8], 2'h3);
        mode[3] = pesel_legal(st_ff.ctrl[7:6], 2'h0);
        mode[2] = pesel_legal(st_ff.ctrl[5:4], 2'h0);
        mode[1] = pesel_legal(st_ff.ctrl[3:2], 2'h0);
        mode[0] = pesel_legal(st_ff.ctrl[1:0], 2'h2);
        for (int i = 0; i < PESEL_NUM_PINS; i++) begin
            bad[i] = (mode[i] != st_ff.ctrl[2*i +: 2]);
        end
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic [15:0] wv;
        logic [6:0] to, toe;
        nxt_st = st_ff;
        wv = st_ff.ctrl;
        to = '0;
        toe = '0;
        // The boot strap is caught on the first clock after reset release.
        if (st_ff.boot_pend) begin
            nxt_st.boot_pend = 1'b0;
            nxt_st.ctrl = boot_ext8 ? PESEL_CTRL2_RESET_EXT8 : PESEL_CTRL2_RESET;
        end
        if (s_axi_awvalid && s_axi_awready) begin
            nxt_st.aw_got = 1'b1;
            nxt_st.awaddr = s_axi_awaddr[11:0];
        end
        if (s_axi_wvalid && s_axi_wready) begin
            nxt_st.w_got = 1'b1;
            nxt_st.wdata = s_axi_wdata;
            nxt_st.wstrb = s_axi_wstrb;
        end
        if (st_ff.aw_got && st_ff.w_got && !st_ff.bvalid) begin
            nxt_st.aw_got = 1'b0;
            nxt_st.w_got = 1'b0;
            nxt_st.bvalid = 1'b1;
            if (st_ff.awaddr[11:2] == PESEL_CTRL2_OFFSET[11:2]) begin
                if (st_ff.wstrb[0]) begin
                    wv[7:0] = st_ff.wdata[7:0];
                end
                if (st_ff.wstrb[1]) begin
                    wv[15:8] = st_ff.wdata[15:8];
                end
                nxt_st.ctrl = wv & PESEL_CTRL2_WMASK;
                nxt_st.bresp = PESEL_RESP_OKAY;
            end else if (st_ff.awaddr[11:2] == PESEL_STATUS_OFFSET[11:2]) begin
                nxt_st.bresp = PESEL_RESP_OKAY;
            end else begin
                nxt_st.bresp = PESEL_RESP_SLVERR;
            end
        end
        if (st_ff.bvalid && s_axi_bready) begin
            nxt_st.bvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            nxt_st.rvalid = 1'b1;
            nxt_st.rresp = PESEL_RESP_OKAY;
            if (s_axi_araddr[11:2] == PESEL_CTRL2_OFFSET[11:2]) begin
                nxt_st.rdata = {16'h0000, st_ff.ctrl};
            end else if (s_axi_araddr[11:2] == PESEL_STATUS_OFFSET[11:2]) begin
                nxt_st.rdata = {24'h000000, |bad, bad};
            end else begin
                nxt_st.rdata = 32'h00000000;
                nxt_st.rresp = PESEL_RESP_SLVERR;
            end
        end else if (st_ff.rvalid && s_axi_rready) begin
            nxt_st.rvalid = 1'b0;
        end
        // Pin output mux.
        for (int i = 0; i < PESEL_NUM_PINS; i++) begin
            to[i] = port_out[i];
            toe[i] = port_oe[i] & (mode[i] == PESEL_MODE_PORT);
        end
        if (mode[6] == PESEL_MODE_TIMER) begin
            to[6] = timer_ch2_a_io_o;
            toe[6] = timer_ch2_a_io_oe;
        end else if (mode[6] == PESEL_MODE_SERIAL) begin
            to[6] = serial3_clock_o;
            toe[6] = serial3_clock_oe;
        end else if (mode[6] == PESEL_MODE_BUS) begin
            to[6] = ext_addr_hi[2];
            toe[6] = 1'b1;
        end
        if (mode[5] == PESEL_MODE_TIMER) begin
            to[5] = timer_ch1_b_io_o;
            toe[5] = timer_ch1_b_io_oe;
        end else if (mode[5] == PESEL_MODE_SERIAL) begin
            to[5] = serial3_transmit;
            toe[5] = 1'b1;
        end else if (mode[5] == PESEL_MODE_BUS) begin
            to[5] = ext_addr_hi[1];
            toe[5] = 1'b1;
        end
        if (mode[4] == PESEL_MODE_TIMER) begin
            to[4] = timer_ch1_a_io_o;
            toe[4] = timer_ch1_a_io_oe;
        end else if (mode[4] == PESEL_MODE_BUS) begin
            to[4] = ext_addr_hi[0];
            toe[4] = 1'b1;
        end
        if (mode[3] == PESEL_MODE_TIMER) begin
            to[3] = timer_ch0_d_io_o;
            toe[3] = timer_ch0_d_io_oe;
        end
        if (mode[2] == PESEL_MODE_TIMER) begin
            to[2] = timer_ch0_c_io_o;
            toe[2] = timer_ch0_c_io_oe;
        end
        if (mode[1] == PESEL_MODE_TIMER) begin
            to[1] = timer_ch0_b_io_o;
            toe[1] = timer_ch0_b_io_oe;
        end
        if (mode[0] == PESEL_MODE_TIMER) begin
            to[0] = timer_ch0_a_io_o;
            toe[0] = timer_ch0_a_io_oe;
        end else if (mode[0] == PESEL_MODE_BUS) begin
            to[0] = chip_select_zero_n;
            toe[0] = 1'b1;
        end
        nxt_st.pout = to;
        nxt_st.poe = toe;
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            st_ff <= '{ctrl: PESEL_CTRL2_RESET, boot_pend: 1'b1, bresp: PESEL_RESP_OKAY,
                       rresp: PESEL_RESP_OKAY, default: '0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Write channels stall while the strap is caught so a write cannot be overwritten by it.
    assign s_axi_awready = !st_ff.aw_got && !st_ff.boot_pend;
    assign s_axi_wready = !st_ff.w_got && !st_ff.boot_pend;
    assign s_axi_bvalid = st_ff.bvalid;
    assign s_axi_bresp = st_ff.bresp;
    assign s_axi_arready = !st_ff.rvalid;
    assign s_axi_rvalid = st_ff.rvalid;
    assign s_axi_rdata = st_ff.rdata;
    assign s_axi_rresp = st_ff.rresp;
    assign pin_out = st_ff.pout;
    assign pin_oe = st_ff.poe;

    always_comb begin
        for (int i = 0; i < PESEL_NUM_PINS; i++) begin
            pin_to_port[i] = (mode[i] == PESEL_MODE_PORT) & pin_in[i];
            pin_timer_sel[i] = (mode[i] == PESEL_MODE_TIMER);
        end
        serial3_clock_in = (mode[6] == PESEL_MODE_SERIAL) ? pin_in[6] : 1'b0;
        serial3_receive = (mode[4] == PESEL_MODE_SERIAL) ? pin_in[4] : 1'b1;
    end

    pesel_edge_if #(.N(EDGE_PINS)) eif ();
    assign eif.pin_level = edge_pin_level;
    assign eif.edge_mode = edge_mode;
    assign edge_event = eif.edge_event;
    pesel_edge_watch #(.N(EDGE_PINS)) u_edge (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .eif(eif.watcher)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_boot_strap: assert property (@(posedge clk_sys) disable iff (!rstn)
        (st_ff.boot_pend && boot_ext8) |=> st_ff.ctrl == PESEL_CTRL2_RESET_EXT8)
        else $error("ext8 boot did not set the reset fields");
    a_pin6_serial: assert property (@(posedge clk_sys) disable iff (!rstn)
        (st_ff.ctrl[13:12] == 2'h2) |=> (pin_oe[6] == $past(serial3_clock_oe)))
        else $error("pin 6 serial clock enable not routed");
    a_pin5_addr: assert property (@(posedge clk_sys) disable iff (!rstn)
        (st_ff.ctrl[11:10] == 2'h3) |=> (pin_oe[5] && pin_out[5] == $past(ext_addr_hi[1])))
        else $error("pin 5 address bit not routed");
    a_pin4_rx: assert property (@(posedge clk_sys) disable iff (!rstn)
        (st_ff.ctrl[9:8] == 2'h2) |-> (serial3_receive == pin_in[4]))
        else $error("pin 4 receive not routed");
    a_pin3_bad: assert property (@(posedge clk_sys) disable iff (!rstn)
        st_ff.ctrl[7] |=> (pin_oe[3] == $past(port_oe[3])))
        else $error("pin 3 prohibited code not treated as port");
    a_pin2_timer: assert property (@(posedge clk_sys) disable iff (!rstn)
        (st_ff.ctrl[5:4] == 2'h1) |=> (pin_out[2] == $past(timer_ch0_c_io_o)))
        else $error("pin 2 timer not routed");
    a_pin1_timer: assert property (@(posedge clk_sys) disable iff (!rstn)
        (st_ff.ctrl[3:2] == 2'h1) |=> (pin_oe[1] == $past(timer_ch0_b_io_oe)))
        else $error("pin 1 timer enable not routed");
    a_pin0_bad: assert property (@(posedge clk_sys) disable iff (!rstn)
        (st_ff.ctrl[1:0] == 2'h2) |-> (pin_to_port[0] == pin_in[0]) ##1 (pin_oe[0] == $past(port_oe[0])))
        else $error("pin 0 prohibited code not treated as port");
    a_bad_port: assert property (@(posedge clk_sys) disable iff (!rstn)
        st_ff.ctrl[5] |-> pin_timer_sel[2] == 1'b0 && pin_to_port[2] == pin_in[2])
        else $error("prohibited code reached a peripheral");
endmodule // pesel_top

/* File: tb/pesel_periph_model.sv */
// Behavioural model of the timer, serial and bus controller outputs that feed the pin mux.
`timescale 1ns/1ps
module pesel_periph_model (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [15:0] pattern,
    output logic [6:0] tim_o,
    output logic [6:0] tim_oe,
    output logic sclk_o,
    output logic sclk_oe,
    output logic tx,
    output logic [2:0] addr_hi,
    output logic cs_n
);
    logic [22:0] state_ff;
    // Real peripherals launch from flops, so every change lands just after a clock edge.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state_ff <= 23'h000000;
        end else begin
            state_ff <= {pattern, pattern[6:0] ^ 7'h55};
        end
    end
    assign tim_o = state_ff[6:0];
    assign tim_oe = state_ff[13:7];
    assign addr_hi = state_ff[16:14];
    assign cs_n = state_ff[17];
    assign tx = state_ff[20];
    assign sclk_o = state_ff[21];
    assign sclk_oe = state_ff[22];
endmodule // pesel_periph_model

/* File: tb/pesel_top_tb.sv */
// Self-checking testbench of the port E low pin function select block.
`timescale 1ns/1ps
module pesel_top_tb
    import pesel_pkg::*;
;
    logic clk_sys, rstn, boot_ext8;
    logic [31:0] awaddr, wdata, araddr, rdata;
    logic [3:0] wstrb;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [1:0] bresp, rresp;
    logic [15:0] pat;
    logic [6:0] tim_o, tim_oe, pin_out, pin_oe, pin_to_port, pin_timer_sel, pin_in;
    logic sclk_o, sclk_oe, tx, cs_n, serial3_clock_in, serial3_receive;
    logic [2:0] addr_hi;
    logic [1:0] lvl, emode, ev;
    int errors = 0;
    int comparisons = 0;
    assign pin_in = pat[6:0] ^ 7'h2a;

    pesel_top #(.EDGE_PINS(2)) i_pesel_top (
        .clk_sys(clk_sys), .rstn(rstn), .boot_ext8(boot_ext8),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .port_out(~pat[6:0]), .port_oe(pat[13:7]),
        .timer_ch2_a_io_o(tim_o[6]), .timer_ch2_a_io_oe(tim_oe[6]),
        .timer_ch1_b_io_o(tim_o[5]), .timer_ch1_b_io_oe(tim_oe[5]),
        .timer_ch1_a_io_o(tim_o[4]), .timer_ch1_a_io_oe(tim_oe[4]),
        .timer_ch0_d_io_o(tim_o[3]), .timer_ch0_d_io_oe(tim_oe[3]),
        .timer_ch0_c_io_o(tim_o[2]), .timer_ch0_c_io_oe(tim_oe[2]),
        .timer_ch0_b_io_o(tim_o[1]), .timer_ch0_b_io_oe(tim_oe[1]),
        .timer_ch0_a_io_o(tim_o[0]), .timer_ch0_a_io_oe(tim_oe[0]),
        .serial3_clock_o(sclk_o), .serial3_clock_oe(sclk_oe), .serial3_transmit(tx),
        .ext_addr_hi(addr_hi), .chip_select_zero_n(cs_n), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .pin_to_port(pin_to_port), .pin_timer_sel(pin_timer_sel),
        .serial3_clock_in(serial3_clock_in), .serial3_receive(serial3_receive),
        .edge_pin_level(lvl), .edge_mode(emode), .edge_event(ev)
    );

    pesel_periph_model i_pesel_periph_model (
        .clk_sys(clk_sys), .rstn(rstn), .pattern(pat), .tim_o(tim_o), .tim_oe(tim_oe),
        .sclk_o(sclk_o), .sclk_oe(sclk_oe), .tx(tx), .addr_hi(addr_hi), .cs_n(cs_n)
    );

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic test_done;
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic do_reset(input logic ext8);
        @(posedge clk_sys);
        boot_ext8 <= ext8;
        rstn <= 1'b0;
        repeat (20) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (3) @(posedge clk_sys);
    endtask

    // Holds each channel until its own handshake edge; only the watchdog ends a stuck wait.
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
        @(posedge clk_sys);
        awaddr <= {20'h00000, a};
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge clk_sys);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                r = bresp;
                bready <= 1'b0;
                break;
            end
        end
    endtask

    task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk_sys);
        araddr <= {20'h00000, a};
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge clk_sys);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                break;
            end
        end
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] exp_r);
        logic [31:0] d;
        logic [1:0] r;
        axi_rd(a, d, r);
        chk(d, exp);
        chk(r, exp_r);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_regs;
        logic [1:0] r;
        axi_wr(PESEL_CTRL2_OFFSET, 32'hffffffff, 4'hf, r);
        chk(r, PESEL_RESP_OKAY);
        rd_chk(PESEL_CTRL2_OFFSET, 32'h00003fff, PESEL_RESP_OKAY);
        axi_wr(PESEL_CTRL2_OFFSET, 32'h00000000, 4'h1, r);
        rd_chk(PESEL_CTRL2_OFFSET, 32'h00003f00, PESEL_RESP_OKAY);
        axi_wr(12'h008, 32'h00001234, 4'hf, r);
        chk(r, PESEL_RESP_SLVERR);
        rd_chk(12'h008, 32'h00000000, PESEL_RESP_SLVERR);
        // Pin 3 code 10 and pin 0 code 10 are both prohibited.
        axi_wr(PESEL_CTRL2_OFFSET, 32'h00000082, 4'hf, r);
        axi_wr(PESEL_STATUS_OFFSET, 32'hffffffff, 4'hf, r);
        chk(r, PESEL_RESP_OKAY);
        rd_chk(PESEL_STATUS_OFFSET, 32'h00000089, PESEL_RESP_OKAY);
    endtask

    task automatic t_route;
        logic [1:0] c, e, r;
        logic [15:0] p;
        logic eo, eoe;
        for (int k = 0; k < 8; k++) begin
            p = k[0] ? 16'ha5c3 : 16'h5a3c;
            c = k[2:1];
            // Port drive and direction go in before the control write on odd passes and after it on even ones.
            if (k[0]) pat <= p;
            // One code on every pin gives each pin its own function for that code, or the port where that code is prohibited.
            axi_wr(PESEL_CTRL2_OFFSET, {18'h00000, {7{c}}}, 4'h3, r);
            if (!k[0]) pat <= p;
            repeat (3) @(posedge clk_sys);
            for (int i = 0; i < 7; i++) begin
                e = ((i >= 1 && i <= 3 && c[1]) || (i == 0 && c == 2'h2)) ? 2'h0 : c;
                case (e)
                    2'h0: begin eo = ~p[i]; eoe = p[7 + i]; end
                    2'h1: begin eo = p[i] ^ k[0] ^ (i % 2 == 0); eoe = p[i]; end
                    2'h2: begin eo = (i == 6) ? p[14] : (i == 5) ? p[13] : 1'b0; eoe = (i == 6) ? p[15] : (i == 5); end
                    default: begin eo = (i == 0) ? p[10] : p[i + 3]; eoe = 1'b1; end
                endcase
                if (e == 2'h1) eo = p[i] ^ ((7'h55 >> i) & 7'h01);
                chk(pin_oe[i], eoe);
                chk(pin_out[i] & eoe, eo & eoe);
                chk(pin_to_port[i], (e == 2'h0) ? pin_in[i] : 1'b0);
                chk(pin_timer_sel[i], e == 2'h1);
            end
            chk(serial3_clock_in, (c == 2'h2) ? pin_in[6] : 1'b0);
            chk(serial3_receive, (c == 2'h2) ? pin_in[4] : 1'b1);
        end
    endtask

    task automatic t_edge;
        lvl <= 2'b10;
        emode <= 2'b00;
        repeat (3) @(posedge clk_sys);
        // Only the pin sitting low registers an edge when switched into edge mode.
        emode <= 2'b11;
        // The pulse is looked at on the falling edge, where the registered output has settled.
        @(posedge clk_sys);
        @(negedge clk_sys);
        chk(ev, 2'b01);
        @(negedge clk_sys);
        chk(ev, 2'b00);
        @(posedge clk_sys);
        lvl <= 2'b00;
        @(posedge clk_sys);
        @(negedge clk_sys);
        chk(ev, 2'b10);
        @(negedge clk_sys);
        chk(ev, 2'b00);
        @(posedge clk_sys);
    endtask

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    initial begin
        repeat (20000) @(posedge clk_sys);
        errors++;
        test_done();
    end

    initial begin
        rstn = 1'b0;
        boot_ext8 = 1'b0;
        awaddr = 32'h00000000;
        wdata = 32'h00000000;
        araddr = 32'h00000000;
        wstrb = 4'h0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        pat = 16'h0000;
        lvl = 2'b00;
        emode = 2'b00;
        do_reset(1'b0);
        rd_chk(PESEL_CTRL2_OFFSET, {16'h0000, PESEL_CTRL2_RESET}, PESEL_RESP_OKAY);
        t_regs();
        t_route();
        t_edge();
        // Port directions are cleared before the reset so no pin is left driving a one.
        pat <= 16'h0000;
        // The 8-bit external boot; its data pins belong to other port registers.
        do_reset(1'b1);
        rd_chk(PESEL_CTRL2_OFFSET, 32'h00003f03, PESEL_RESP_OKAY);
        chk(pin_oe, 7'h71);
        test_done();
    end
endmodule // pesel_top_tb
